// [rtl/isolated_modulator_map.vh]
`ifndef ISOLATED_MODULATOR_MAP_VH
`define ISOLATED_MODULATOR_MAP_VH
// input sample scaling: code per volt is 16000, so 1 V = 16000 and 1.25 V = 20000
`define SAMPLE_WIDTH 16
`define CLIPPING_VOLTAGE_CODE 16'sh4E20
`define LINEAR_FULL_SCALE_RANGE_CODE 16'sh3E80
`define INTEG_WIDTH 24
// chopper runs at modulator clock / 32, toggling every half period
`define CHOP_DIVIDE 32
`define CHOP_HALF_PERIOD 5'h10
// marker bit every 128 modulator clocks while clipped
`define MARKER_PERIOD 128
`define MARKER_COUNT_WIDTH 7
// converter resonator sync pulse every N modulator clocks
`define DCDC_SYNC_DIVIDE 8
// pin synchroniser vector positions
`define PIN_MOD_CLK 0
`define PIN_DIGITAL_OK 1
`define PIN_ANALOG_OK 2
`define PIN_ISO_OK 3
`define PIN_HLDO_OK 4
`define PIN_LINK_OK 5
`define PIN_COUNT 6
`endif

// [rtl/clip_marker.v]
`timescale 1ns/10ps
`include "isolated_modulator_map.vh"
module clip_marker #(
  parameter MARKER_PERIOD = `MARKER_PERIOD,
  parameter CW = `MARKER_COUNT_WIDTH
) (
  input wire core_clk,
  input wire arst_n,
  input wire bitTick,
  input wire clipPos,
  input wire clipNeg,
  input wire modBit,
  output wire streamBit
);
  localparam [31:0] PERIOD32 = MARKER_PERIOD;
  localparam [CW-1:0] LAST_SLOT = PERIOD32[CW-1:0] - 1'b1;
  reg [CW-1:0] markCnt_r;
  reg clipPos_r;
  reg clipNeg_r;
  wire lastSlot;
  wire entering;

  ////////////////////////////////////////////////////////////////////////////
  assign entering = (clipPos & ~clipPos_r) | (clipNeg & ~clipNeg_r);
  assign lastSlot = (markCnt_r == LAST_SLOT);

  // counter only advances on modulator ticks; restarts on each entry into clipping
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      markCnt_r <= {CW{1'b0}};
      clipPos_r <= 1'b0;
      clipNeg_r <= 1'b0;
    end
    else if (bitTick)
    begin
      clipPos_r <= clipPos;
      clipNeg_r <= clipNeg;
      if (entering || !(clipPos || clipNeg))
        markCnt_r <= {CW{1'b0}};
      else
        markCnt_r <= markCnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clipped stream is all zeros or all ones, with one opposite bit per period
  assign streamBit = clipPos ? ~(lastSlot & ~entering) :
                     clipNeg ? (lastSlot & ~entering) :
                     modBit;
endmodule // clip_marker

// [rtl/isolated_modulator.v]
// Function
// - input buffer chopped at modulator clock divided by 32.
// - one-bit quantizer decision takes effect on the next modulator clock.
// - zero input gives a stream of 50 percent ones.
// - plus one volt gives 90 percent ones, code 58982 at 16 bits.
// - minus one volt gives 10 percent ones, code 6553 at 16 bits.
// - at or beyond 1.25 volts the stream clips to all zeros or ones.
// - while clipped, one opposite bit every 128 clocks shows the high side alive.
// - ones density equals input plus clip voltage over twice clip voltage.
// - each one bit keys the barrier carrier on, each zero keys it off.
// - isolated supply below undervoltage forces a zero stream.
// - health flag held low until supply regulates and bits flow.
// - no bits from high side pulls flag low and stream low.
// - isolated or regulator undervoltage pulls flag low and stream to zeros.
// - health flag is open drain, released when output bits are valid or below the digital reset threshold.
// - converter resonator synchronised to modulator clock.
// - host supplies the clock; one output bit per clock.
// - each output bit launched from the modulator clock rising edge.
// - digital outputs work above the digital reset threshold, before analog.
// - below digital reset threshold, digital outputs are not driven.
`timescale 1ns/10ps
`include "isolated_modulator_map.vh"
module isolated_modulator #(
  parameter SW = `SAMPLE_WIDTH,
  parameter IW = `INTEG_WIDTH,
  parameter signed [SW-1:0] CLIP_CODE = `CLIPPING_VOLTAGE_CODE,
  parameter signed [SW-1:0] CHOP_OFFSET = 16'sh0000,
  parameter DCDC_SYNC_DIVIDE = `DCDC_SYNC_DIVIDE
) (
  input wire core_clk,
  input wire arst_n,
  input wire modulator_clock_in,
  input wire signed [SW-1:0] inputSample,
  input wire digitalSupplyOk,
  input wire analogSupplyOk,
  input wire isolated_supply_ok,
  input wire high_side_regulator_ok,
  input wire highSideLinkOk,
  output wire bitOut,
  output wire bitOe,
  output wire health_flag_n,
  output wire healthFlagOe,
  output reg carrierOn,
  output reg chopPhase,
  output reg dcdcSyncPulse
);
  localparam [4:0] CHOP_HALF = `CHOP_HALF_PERIOD;
  localparam [31:0] SYNC_DIV32 = DCDC_SYNC_DIVIDE;
  localparam [3:0] SYNC_LAST = SYNC_DIV32[3:0] - 4'h1;

  // sign-extend a sample to integrator width
  function signed [IW-1:0] ext;
    input signed [SW-1:0] v;
    begin
      ext = {{(IW-SW){v[SW-1]}}, v};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three flops, a change counts once stages two and three agree
  reg [`PIN_COUNT-1:0] pinS1_r;
  reg [`PIN_COUNT-1:0] pinS2_r;
  reg [`PIN_COUNT-1:0] pinS3_r;
  reg [`PIN_COUNT-1:0] pinF_r;
  wire [`PIN_COUNT-1:0] pinRaw;
  wire [`PIN_COUNT-1:0] pinF_nxt;

  assign pinRaw = {highSideLinkOk, high_side_regulator_ok, isolated_supply_ok,
                   analogSupplyOk, digitalSupplyOk, modulator_clock_in};
  assign pinF_nxt = (pinS2_r & ~(pinS2_r ^ pinS3_r)) | (pinF_r & (pinS2_r ^ pinS3_r));

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pinS1_r <= {`PIN_COUNT{1'b0}};
      pinS2_r <= {`PIN_COUNT{1'b0}};
      pinS3_r <= {`PIN_COUNT{1'b0}};
      pinF_r <= {`PIN_COUNT{1'b0}};
    end
    else
    begin
      pinS1_r <= pinRaw;
      pinS2_r <= pinS1_r;
      pinS3_r <= pinS2_r;
      pinF_r <= pinF_nxt;
    end
  end

  wire bitTick;
  wire digitalOk;
  wire analogOk;
  wire supplyOk;
  wire linkOk;
  wire running;
  // one bit per host clock rising edge
  assign bitTick = pinF_nxt[`PIN_MOD_CLK] & ~pinF_r[`PIN_MOD_CLK];
  assign digitalOk = pinF_r[`PIN_DIGITAL_OK];
  assign analogOk = pinF_r[`PIN_ANALOG_OK] & digitalOk;
  assign supplyOk = pinF_r[`PIN_ISO_OK] & pinF_r[`PIN_HLDO_OK];
  assign linkOk = pinF_r[`PIN_LINK_OK];
  assign running = analogOk & supplyOk;

  ////////////////////////////////////////////////////////////////////////////
  // chopper and converter sync, both counted in modulator clocks
  reg [4:0] chopCnt_r;
  reg [3:0] syncCnt_r;

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      chopCnt_r <= 5'h00;
      chopPhase <= 1'b0;
      syncCnt_r <= 4'h0;
      dcdcSyncPulse <= 1'b0;
    end
    else
    begin
      dcdcSyncPulse <= 1'b0;
      if (bitTick && running)
      begin
        if (chopCnt_r == CHOP_HALF - 1'b1)
        begin
          chopCnt_r <= 5'h00;
          chopPhase <= ~chopPhase;
        end
        else
          chopCnt_r <= chopCnt_r + 1'b1;
        if (syncCnt_r == SYNC_LAST)
        begin
          syncCnt_r <= 4'h0;
          dcdcSyncPulse <= 1'b1;
        end
        else
          syncCnt_r <= syncCnt_r + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // second-order modulator, feedback levels of plus and minus clip voltage
  reg signed [IW-1:0] integ1_r;
  reg signed [IW-1:0] integ2_r;
  reg quantBit_r;
  reg started_r;
  wire signed [IW-1:0] fb;
  wire signed [IW-1:0] xin;
  wire signed [IW-1:0] integ1_nxt;
  wire signed [IW-1:0] integ2_nxt;
  wire clipPos;
  wire clipNeg;

  // chopped offset flips sign every half chop period, so it averages out
  assign xin = ext(inputSample) + (chopPhase ? ext(CHOP_OFFSET) : -ext(CHOP_OFFSET));
  assign fb = quantBit_r ? ext(CLIP_CODE) : -ext(CLIP_CODE);
  assign integ1_nxt = integ1_r + xin - fb;
  assign integ2_nxt = integ2_r + integ1_nxt - fb;
  assign clipPos = inputSample >= CLIP_CODE;
  assign clipNeg = inputSample <= -CLIP_CODE;

  // integrators held at zero while clipped, so leaving full scale has no windup
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      integ1_r <= {IW{1'b0}};
      integ2_r <= {IW{1'b0}};
      quantBit_r <= 1'b0;
      started_r <= 1'b0;
    end
    else if (!running)
    begin
      integ1_r <= {IW{1'b0}};
      integ2_r <= {IW{1'b0}};
      quantBit_r <= 1'b0;
      started_r <= 1'b0;
    end
    else if (bitTick)
    begin
      started_r <= 1'b1;
      if (clipPos || clipNeg)
      begin
        integ1_r <= {IW{1'b0}};
        integ2_r <= {IW{1'b0}};
        quantBit_r <= clipPos;
      end
      else
      begin
        integ1_r <= integ1_nxt;
        integ2_r <= integ2_nxt;
        // density tracks (vin + clip) / (2 clip): 50, 90, 10 percent at 0, +1, -1 V
        quantBit_r <= ~integ2_nxt[IW-1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // full-scale limiting and marker insertion
  wire streamBit;

  clip_marker #(
    .MARKER_PERIOD(`MARKER_PERIOD),
    .CW(`MARKER_COUNT_WIDTH)
  ) uMarker (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .bitTick(bitTick),
    .clipPos(clipPos),
    .clipNeg(clipNeg),
    .modBit(quantBit_r),
    .streamBit(streamBit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // output stage: bit launched on each host clock rise, zeros on any fault
  reg bitOut_r;
  reg healthy_r;
  wire validNow;

  assign validNow = running & linkOk & started_r;

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bitOut_r <= 1'b0;
      carrierOn <= 1'b0;
      healthy_r <= 1'b0;
    end
    else
    begin
      // fault response is immediate, not waiting for the next host clock
      if (!validNow)
      begin
        bitOut_r <= 1'b0;
        carrierOn <= 1'b0;
      end
      else if (bitTick)
      begin
        bitOut_r <= streamBit;
        carrierOn <= streamBit;
      end
      healthy_r <= validNow;
    end
  end

  // both pins float below the digital reset threshold
  assign bitOut = bitOut_r;
  assign bitOe = digitalOk;
  assign health_flag_n = 1'b0;
  assign healthFlagOe = digitalOk & ~healthy_r;
endmodule // isolated_modulator

// [sim/isolated_modulator_properties.sv]
`timescale 1ns/10ps
module isolated_modulator_properties (
  input wire core_clk,
  input wire arst_n,
  input wire modulator_clock_in,
  input wire digitalSupplyOk,
  input wire isolated_supply_ok,
  input wire high_side_regulator_ok,
  input wire highSideLinkOk,
  input wire bitOut,
  input wire bitOe,
  input wire health_flag_n,
  input wire healthFlagOe,
  input wire carrierOn,
  input wire dcdcSyncPulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////
  // six cycles cover pin sync latency plus the output register
  property p_ook; bitOut |-> carrierOn; endproperty
  a_ook: assert property (p_ook) else $error("carrier off for a one");
  property p_iso; !isolated_supply_ok [*6] |-> !bitOut; endproperty
  a_iso: assert property (p_iso) else $error("stream not zero on supply fault");
  property p_hldo; (!high_side_regulator_ok && digitalSupplyOk) [*6] |-> !bitOut && healthFlagOe; endproperty
  a_hldo: assert property (p_hldo) else $error("regulator fault not flagged");
  property p_link; (!highSideLinkOk && digitalSupplyOk) [*6] |-> !bitOut && healthFlagOe; endproperty
  a_link: assert property (p_link) else $error("link loss not flagged");
  property p_od; healthFlagOe |-> !health_flag_n; endproperty
  a_od: assert property (p_od) else $error("flag driven high");
  property p_off; !digitalSupplyOk [*6] |-> !bitOe && !healthFlagOe; endproperty
  a_off: assert property (p_off) else $error("pins driven while unpowered");
  property p_on; digitalSupplyOk [*6] |-> bitOe; endproperty
  a_on: assert property (p_on) else $error("output not driven");
  property p_launch; $rose(bitOut) |-> $past(modulator_clock_in, 4); endproperty
  a_launch: assert property (p_launch) else $error("bit not launched from clock rise");
  property p_sync; dcdcSyncPulse |=> !dcdcSyncPulse; endproperty
  a_sync: assert property (p_sync) else $error("sync pulse too long");
endmodule // isolated_modulator_properties
bind isolated_modulator isolated_modulator_properties i_props (.core_clk(core_clk), .arst_n(arst_n),
  .modulator_clock_in(modulator_clock_in), .digitalSupplyOk(digitalSupplyOk),
  .isolated_supply_ok(isolated_supply_ok), .high_side_regulator_ok(high_side_regulator_ok),
  .highSideLinkOk(highSideLinkOk), .bitOut(bitOut), .bitOe(bitOe), .health_flag_n(health_flag_n),
  .healthFlagOe(healthFlagOe), .carrierOn(carrierOn), .dcdcSyncPulse(dcdcSyncPulse));

// [sim/bitstream_filter.sv]
`timescale 1ns/10ps
module bitstream_filter (
  input wire core_clk,
  input wire run,
  input wire clr,
  input wire bitOut,
  output reg modulator_clock_in,
  output integer ones,
  output integer bits
);
  reg [2:0] phase;
  initial
  begin
    modulator_clock_in = 1'b0;
    phase = 3'h0;
  end
  // host clock, 8 core cycles; a started period always completes
  always @(negedge core_clk)
  begin
    if (run || phase != 3'h0)
      phase <= phase + 3'h1;
    modulator_clock_in <= phase[2];
    // sample the bit launched one host clock earlier, first stage of decimation
    if (clr)
    begin
      ones <= 0;
      bits <= 0;
    end
    else if (phase == 3'h4)
    begin
      ones <= ones + bitOut;
      bits <= bits + 1;
    end
  end
endmodule // bitstream_filter

// [sim/testbench.sv]
`timescale 1ns/10ps
`include "isolated_modulator_map.vh"
module testbench;
  reg core_clk, arst_n, run, clr, dOk, aOk, isoOk, hOk, lOk, chopQ;
  reg signed [15:0] sample;
  wire bitOut, bitOe, flagN, flagOe, carrier, chop, sync, modClk, flagPin;
  integer ones, bits, fails, checks_done, chopN, syncN, i, k;
  isolated_modulator i_dut (.core_clk(core_clk), .arst_n(arst_n), .modulator_clock_in(modClk),
    .inputSample(sample), .digitalSupplyOk(dOk), .analogSupplyOk(aOk), .isolated_supply_ok(isoOk),
    .high_side_regulator_ok(hOk), .highSideLinkOk(lOk), .bitOut(bitOut), .bitOe(bitOe),
    .health_flag_n(flagN), .healthFlagOe(flagOe), .carrierOn(carrier), .chopPhase(chop),
    .dcdcSyncPulse(sync));
  bitstream_filter i_filt (.core_clk(core_clk), .run(run), .clr(clr), .bitOut(bitOut),
    .modulator_clock_in(modClk), .ones(ones), .bits(bits));
  // open-drain flag line as the host sees it, with its pull-up
  assign flagPin = flagOe ? flagN : 1'b1;
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    chopQ <= chop;
    if (chop !== chopQ) chopN = chopN + 1;
    if (sync === 1'b1) syncN = syncN + 1;
  end
  ////////////////////////////////////////////////////////////////
  function integer near(input integer got, input integer exp, input integer tol);
    near = (got >= exp - tol) && (got <= exp + tol);
  endfunction
  function integer expOnes(input integer v, input integer n);
    expOnes = (v + `CLIPPING_VOLTAGE_CODE) * n / (2 * `CLIPPING_VOLTAGE_CODE);
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
  begin
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
    end
  end
  endtask
  task give_verdict;
  begin
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  // clear the filter, then wait for n bits under a bound
  task collect(input integer n);
    integer t;
  begin
    @(negedge core_clk) clr <= 1'b1;
    @(negedge core_clk) clr <= 1'b0;
    @(negedge core_clk);
    chopN = 0;
    syncN = 0;
    t = 0;
    while (bits < n && t < n * 10)
    begin
      @(negedge core_clk);
      t = t + 1;
    end
    if (t >= n * 10)
    begin
      fails = fails + 1;
      give_verdict;
    end
  end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    {arst_n, run, clr, chopQ} = 4'h0;
    {dOk, aOk, isoOk, hOk, lOk} = 5'h1F;
    sample = 16'sh0000;
    {fails, checks_done, chopN, syncN} = 0;
    k = $urandom(77822);
    repeat (3) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (10) @(negedge core_clk);
    check(flagOe, 1);
    check(flagPin, 0);
    run <= 1'b1;
    // clip entry at the exact boundary and beyond it
    for (i = 0; i < 2; i = i + 1)
    begin
      sample <= i ? -`CLIPPING_VOLTAGE_CODE - 16'sh1388 : `CLIPPING_VOLTAGE_CODE;
      collect(300);
      // first pass also counts one bit before the first tick and one before the stream starts
      check(near(ones, i ? 2 : 296, 1), 1);
      check(carrier, i ? 32'h0 : 32'h1);
      check(flagOe, 0);
      check(flagPin, 1);
      $display("clip test %0d done", i);
    end
    // zero, both linear ends, then random codes
    for (i = 0; i < 6; i = i + 1)
    begin
      sample <= i == 0 ? 16'sh0000 : i == 1 ? `LINEAR_FULL_SCALE_RANGE_CODE :
        i == 2 ? -`LINEAR_FULL_SCALE_RANGE_CODE : $signed($urandom % 32001) - 16000;
      collect(50);
      collect(1000);
      check(near(ones, expOnes(sample, 1000), 8), 1);
      check(near(chopN, 1000 * 2 / `CHOP_DIVIDE, 2), 1);
      check(near(syncN, 1000 / `DCDC_SYNC_DIVIDE, 2), 1);
      $display("density test %0d done", i);
    end
    // one supply or link fault at a time, with an all-ones input
    sample <= `CLIPPING_VOLTAGE_CODE;
    for (i = 0; i < 4; i = i + 1)
    begin
      {aOk, isoOk, hOk, lOk} <= ~(4'h1 << i);
      repeat (12) @(negedge core_clk);
      check(bitOut, 0);
      check(flagOe, 1);
      check(carrier, 0);
      {aOk, isoOk, hOk, lOk} <= 4'hF;
      repeat (300) @(negedge core_clk);
      check(flagOe, 0);
      $display("fault test %0d done", i);
    end
    dOk <= 1'b0;
    repeat (10) @(negedge core_clk);
    check({bitOe, flagOe}, 0);
    dOk <= 1'b1;
    repeat (10) @(negedge core_clk);
    check(bitOe, 1);
    $display("power test done");
    give_verdict;
  end
endmodule // testbench
